/* File: test/sbg_buffer_ctrl_test.sv */
// Self-checking bench for the sample buffer gate and trigger control
module sbg_buffer_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, i_rst, reg_wr, reg_rd, active, tick, go, buf_read; // Bench-driven strobes
	logic ce, ext; // Clock enable and external trigger level
	logic [7:0] reg_addr, reg_wdata, aslp, rd_val, rdata; // Register bus and autosleep
	logic [3:0] pulses; // Wake event, within, outside, orientation
	logic [3:0] gap; // Host pace between pops
	logic wake, store, drop_oldest, flush, newest_first, ovf, wm, dflag; // Status outputs
	logic [5:0] count, held; // Sample count and a snapshot of it
	logic [4:0] dcount; // Discard counter
	logic [7:0] en_tab [3] = '{8'h08, 8'h04, 8'h01}; // Trigger enable bits
	logic [3:0] src_tab [3] = '{4'h4, 4'h2, 4'h1}; // Matching event pulses
	int num_errors, check_count;
	sbg_buffer_ctrl u_sbg_buffer_ctrl (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
		.i_active(active), .i_external_trigger_mode_mode(ext), .i_autosleep_period(aslp),
		.i_wake_event(pulses[3]), .i_sample_tick(tick), .i_buf_read(buf_read),
		.i_evt_within(pulses[2]), .i_evt_outside(pulses[1]), .i_evt_orient(pulses[0]),
		.o_wake(wake), .o_store(store), .o_drop_oldest(drop_oldest), .o_flush(flush),
		.o_read_newest_first(newest_first), .o_sample_count(count), .o_overflow_flag(ovf),
		.o_watermark_flag(wm), .o_gate_discard_flag(dflag), .o_gate_discard_count(dcount)
	);
	sbg_host_model u_sbg_host_model (
		.i_clk(i_clk), .i_go(go), .i_gap(gap), .i_count(count), .o_buf_read(buf_read)
	);
	// Free-running 50 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One-cycle write strobe; a low cycle always follows before the next access
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge i_clk);
		reg_wr = 1'b0;
	endtask
	// Read data is registered, so it is taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge i_clk);
		reg_rd = 1'b0;
		d = rdata;
	endtask
	task automatic tick_n(input int n);
		repeat (n) begin
			@(negedge i_clk);
			tick = 1'b1;
			@(negedge i_clk);
			tick = 1'b0;
		end
	endtask
	task automatic pulse(input logic [3:0] p);
		@(negedge i_clk);
		pulses = p;
		@(negedge i_clk);
		pulses = 4'h0;
	endtask
	// Kind 0 ticks until SLEEP, kind 1 waits for WAKE, kind 2 waits for an empty buffer
	task automatic wait_cond(input int kind);
		int n;
		for (n = 0; n < 40; n++) begin
			if ((kind == 0 && wake === 1'b0) || (kind == 1 && wake === 1'b1)) break;
			if (kind == 2 && count === 6'h00) break;
			if (kind == 0) tick_n(1);
			else repeat (4) @(negedge i_clk);
		end
		if (n == 40) begin
			num_errors++;
			$display("wrong value wait kind %0d expected done seen timeout", kind);
			close_out();
		end
	endtask
	initial begin
		i_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		active = 1'b0;
		ce = 1'b1;
		ext = 1'b0;
		tick = 1'b0;
		pulses = 4'h0;
		go = 1'b0;
		gap = 4'h2;
		aslp = 8'h00;
		repeat (6) @(negedge i_clk);
		i_rst = 1'b0;
		// Reset values, register layout and a self-clearing flush bit
		rd(sbg_pkg::ADDR_CFG_PRI, rd_val);
		check("primary reset", 8'h00, rd_val);
		rd(sbg_pkg::ADDR_CFG_SEC, rd_val);
		check("secondary reset", 8'h00, rd_val);
		wr(sbg_pkg::ADDR_CFG_SEC, 8'hff);
		rd(sbg_pkg::ADDR_CFG_SEC, rd_val);
		check("secondary fields", 8'h7f, rd_val);
		rd(8'h30, rd_val);
		check("unmapped read", 8'h00, rd_val);
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h80);
		check("read order", 8'h01, {7'h00, newest_first});
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h00);
		$display("test registers done");
		// Streaming with a watermark, then a STANDBY to ACTIVE flush, then disable
		wr(sbg_pkg::ADDR_CFG_SEC, 8'h02);
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h20);
		active = 1'b1;
		tick_n(3);
		check("stream count", 8'h03, {2'h0, count});
		check("watermark flag", 8'h01, {7'h00, wm});
		// A low clock enable freezes the count whatever arrives
		ce = 1'b0;
		tick_n(2);
		check("frozen count", 8'h03, {2'h0, count});
		ce = 1'b1;
		active = 1'b0;
		@(negedge i_clk);
		active = 1'b1;
		repeat (2) @(negedge i_clk);
		check("count after activate", 8'h00, {2'h0, count});
		tick_n(3);
		// STANDBY to external trigger mode flushes too
		active = 1'b0;
		@(negedge i_clk);
		ext = 1'b1;
		repeat (2) @(negedge i_clk);
		check("count after ext mode", 8'h00, {2'h0, count});
		active = 1'b1;
		ext = 1'b0;
		tick_n(3);
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h00);
		repeat (2) @(negedge i_clk);
		check("count after disable", 8'h00, {2'h0, count});
		check("watermark after disable", 8'h00, {7'h00, wm});
		$display("test stream done");
		// Gate on: contents kept across the sleep change, discards tracked and saturated
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h30);
		tick_n(1);
		aslp = 8'h02;
		wait_cond(0);
		held = count;
		tick_n(2);
		check("gated count", {2'h0, held}, {2'h0, count});
		check("discard flag", 8'h01, {7'h00, dflag});
		check("discard count", 8'h02, {3'h0, dcount});
		tick_n(31);
		check("discard saturate", 8'h1f, {3'h0, dcount});
		go = 1'b1;
		wait_cond(2);
		go = 1'b0;
		@(negedge i_clk);
		check("flag after empty", 8'h00, {7'h00, dflag});
		check("discards after empty", 8'h00, {3'h0, dcount});
		tick_n(1);
		check("reopened store", 8'h01, {2'h0, count});
		$display("test gate done");
		// Gate off: both automatic changes flush the buffer
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h20);
		pulse(4'h8);
		wait_cond(1);
		repeat (2) @(negedge i_clk);
		check("flush on wake", 8'h00, {2'h0, count});
		wait_cond(0);
		repeat (2) @(negedge i_clk);
		check("flush on sleep", 8'h00, {2'h0, count});
		aslp = 8'h00;
		pulse(4'h8);
		wait_cond(1);
		$display("test ungated done");
		// Triggered capture from each source in turn
		for (int i = 0; i < 3; i++) begin
			wr(sbg_pkg::ADDR_CFG_SEC, 8'h84);
			wr(sbg_pkg::ADDR_CFG_PRI, 8'h60 | en_tab[i]);
			tick_n(6);
			check("pre-trigger count", 8'h04, {2'h0, count});
			check("pre-trigger watermark", 8'h01, {7'h00, wm});
			@(negedge i_clk);
			tick = 1'b1;
			#1 check("pre-trigger drop", 8'h01, {7'h00, store & drop_oldest});
			@(negedge i_clk);
			tick = 1'b0;
			pulse(4'h7 & ~src_tab[i]);
			tick_n(2);
			check("disabled source", 8'h04, {2'h0, count});
			pulse(src_tab[i]);
			tick_n(30);
			check("post-trigger count", 8'h20, {2'h0, count});
			check("overflow set", 8'h01, {7'h00, ovf});
			pulse(src_tab[i]);
			tick_n(1);
			check("halted count", 8'h20, {2'h0, count});
			if (i == 2) wr(sbg_pkg::ADDR_CFG_PRI, 8'h00);
			else wr(sbg_pkg::ADDR_CFG_SEC, 8'h84);
			repeat (2) @(negedge i_clk);
			check("count cleared", 8'h00, {2'h0, count});
			check("overflow cleared", 8'h00, {7'h00, ovf});
		end
		$display("test trigger done");
		// Triggered collection with autosleep: sleep flush, capture, rearm after sleep
		wr(sbg_pkg::ADDR_CFG_SEC, 8'h84);
		aslp = 8'h02;
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h61);
		wait_cond(0);
		check("sleep flush pulse", 8'h01, {7'h00, flush});
		check("count at sleep", 8'h00, {2'h0, count});
		tick_n(6);
		check("sleep pre count", 8'h04, {2'h0, count});
		pulse(4'h1);
		check("woken by trigger", 8'h01, {7'h00, wake});
		tick_n(30);
		check("combo post count", 8'h20, {2'h0, count});
		check("combo overflow", 8'h01, {7'h00, ovf});
		pulse(4'h1);
		tick_n(1);
		check("stays awake", 8'h01, {7'h00, wake});
		wr(sbg_pkg::ADDR_CFG_SEC, 8'h84);
		pulse(4'h1);
		wait_cond(0);
		tick_n(2);
		check("rearmed after sleep", 8'h02, {2'h0, count});
		wr(sbg_pkg::ADDR_CFG_PRI, 8'h00);
		aslp = 8'h00;
		$display("test combo done");
		close_out();
	end
endmodule

/* File: test/sbg_host_model.sv */
// Host-side model that pops samples out of the buffer at a chosen pace
module sbg_host_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_gap,
	input wire logic [5:0] i_count,
	output logic o_buf_read
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_n; // Idle cycles left before the next pop
	// One pop pulse, then a gap, so that slow readers are exercised as well
	initial begin
		o_buf_read = 1'b0;
		wait_n = 0;
		forever begin
			@(negedge i_clk);
			if (o_buf_read) begin
				o_buf_read = 1'b0;
				wait_n = int'(i_gap);
			end else if (wait_n > 0) begin
				wait_n--;
			end else if (i_go && i_count != 6'h00) begin
				// Pop only while data is held, as a real host polls the count first
				o_buf_read = 1'b1;
			end
		end
	end
endmodule

/* File: verilog/sbg_buffer_ctrl.sv */
// Sample buffer control: input gate, discard tracking, triggers, flush and auto wake/sleep
// How it works
// [RULE1] Gate off: flush buffer on auto wake/sleep change
// [RULE2] Gate on: close input until emptied or flushed
// [RULE3] Discard flag set, held until buffer emptied
// [RULE4] Discard counter counts discards since flag set
// [RULE5] Gate on: keep contents, still change power mode
// [RULE6] After flush, store at current mode rate
// [RULE7] Gate ignored in triggered mode with autosleep
// [RULE8] Trigger accepted only from enabled sources
// [RULE9] Flush on disable, flush request, ungated transition
// [RULE10] Flush on entering active or external trigger
// [RULE11] Disable clears overflow, watermark and sample count
// [RULE12] Discard flag/count cleared on disable, flush, empty
// [RULE13] Combined mode: wake at once, sleep after period
// [RULE14] Pre-trigger: circular, at most watermark_level samples
// [RULE15] Post-trigger: stay awake, ignore further triggers
// [RULE16] Store 32 minus watermark, overflow, then stop
// [RULE17] Rearm on empty/flush; capture needs sleep first
// [RULE18] Combined mode: flush on every wake-to-sleep
// [RULE19] Wake-holding events block triggered collection
// [RULE20] Secondary register: flush, keep-awake, watermark fields
// [RULE21] Mode codes: disabled, stream, stop, triggered
// [RULE22] Flush request self-clears, never reads as one
// [RULE23] Watermark flag when count reaches nonzero level
// [RULE24] Discard counter saturates instead of wrapping
module sbg_buffer_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	input wire logic i_active,
	input wire logic i_external_trigger_mode_mode,
	input wire logic [7:0] i_autosleep_period,
	input wire logic i_wake_event,
	input wire logic i_sample_tick,
	input wire logic i_buf_read,
	input wire logic i_evt_within,
	input wire logic i_evt_outside,
	input wire logic i_evt_orient,
	output logic o_wake,
	output logic o_store,
	output logic o_drop_oldest,
	output logic o_flush,
	output logic o_read_newest_first,
	output logic [5:0] o_sample_count,
	output logic o_overflow_flag,
	output logic o_watermark_flag,
	output logic o_gate_discard_flag,
	output logic [4:0] o_gate_discard_count
);
	// Configuration registers
	logic [7:0] cfg_pri_ff; // buffer_config_primary
	logic [6:0] cfg_sec_ff; // buffer_config_secondary without the self-clearing bit
	// Block state
	sbg_pkg::sbg_pwr_e pwr_ff; // current automatic power mode
	sbg_pkg::sbg_trg_e trg_ff; // triggered collection phase
	logic [7:0] timer_ff; // output-rate periods spent in WAKE
	logic run_ff; // previous active-or-external-trigger level
	logic gate_closed_ff; // buffer input gate is shut
	logic [5:0] cnt_ff; // samples held
	logic [5:0] post_ff; // samples stored since trigger
	logic ovf_ff;
	logic wm_ff;
	logic disc_ff;
	logic [4:0] disc_cnt_ff;
	logic flush_ff;
	logic [7:0] rdata_ff;

	// Qualified strobes; a low clock enable freezes everything
	logic tick, rd, wr_pri, wr_sec;
	assign tick = i_ce & i_sample_tick;
	assign rd = i_ce & i_buf_read & (cnt_ff != 6'h00);
	assign wr_pri = i_ce & i_reg_wr & (i_reg_addr == sbg_pkg::ADDR_CFG_PRI);
	assign wr_sec = i_ce & i_reg_wr & (i_reg_addr == sbg_pkg::ADDR_CFG_SEC);

	// Decoded fields
	sbg_pkg::sbg_mode_e mode;
	logic [5:0] wm;
	logic aslp_on, combo, gate_eff, run, run_rise;
	assign mode = sbg_pkg::sbg_mode_e'(cfg_pri_ff[sbg_pkg::PRI_MODE_HI:sbg_pkg::PRI_MODE_LO]);
	assign wm = cfg_sec_ff[sbg_pkg::SEC_WM_HI:sbg_pkg::SEC_WM_LO];
	assign aslp_on = (i_autosleep_period != 8'h00);
	// Triggered collection combined with automatic sleep
	assign combo = (mode == sbg_pkg::MODE_TRIGGER) && aslp_on;
	// The gate only acts outside the combined mode
	assign gate_eff = cfg_pri_ff[sbg_pkg::PRI_GATE_EN] & ~combo; // [RULE7]
	assign run = i_active | i_external_trigger_mode_mode;
	assign run_rise = i_ce & run & ~run_ff;

	// Trigger sources, each gated by its own enable
	logic trig_hit, trig_take;
	assign trig_hit = (cfg_pri_ff[sbg_pkg::PRI_TRIG_WT] & i_evt_within)
		| (cfg_pri_ff[sbg_pkg::PRI_TRIG_OT] & i_evt_outside)
		| (cfg_pri_ff[sbg_pkg::PRI_TRIG_OR] & i_evt_orient); // [RULE8]
	// With autosleep a capture needs SLEEP first, so a wake hold also blocks it
	assign trig_take = i_ce & run & trig_hit & (mode == sbg_pkg::MODE_TRIGGER)
		& (trg_ff == sbg_pkg::TRG_PRE)
		& (~aslp_on | (pwr_ff == sbg_pkg::PWR_SLEEP)); // [RULE15] [RULE17] [RULE19]

	// Automatic wake/sleep decisions
	logic keep_awake, timer_end, go_sleep, go_wake, auto_tr;
	assign keep_awake = i_wake_event
		| (cfg_sec_ff[sbg_pkg::SEC_KEEP_AWAKE] & (ovf_ff | wm_ff)
		& ((mode == sbg_pkg::MODE_STREAM) | (mode == sbg_pkg::MODE_STOP)));
	assign timer_end = ({1'b0, timer_ff} + 9'h001) >= {1'b0, i_autosleep_period};
	// Once triggered the combined mode holds WAKE whatever the period
	assign go_sleep = tick & run & ~run_rise & (pwr_ff == sbg_pkg::PWR_WAKE) & aslp_on
		& timer_end & ~keep_awake & ~(combo & (trg_ff != sbg_pkg::TRG_PRE)); // [RULE15]
	assign go_wake = i_ce & run & ~run_rise & (pwr_ff == sbg_pkg::PWR_SLEEP)
		& (i_wake_event | (combo & trig_take));
	assign auto_tr = go_sleep | go_wake;

	// Every flush source in one place
	logic mode_off, flush, emptied, clr_all;
	assign mode_off = wr_pri && (i_reg_wdata[sbg_pkg::PRI_MODE_HI:sbg_pkg::PRI_MODE_LO]
		== sbg_pkg::MODE_DISABLED) && (mode != sbg_pkg::MODE_DISABLED); // [RULE9]
	assign flush = (wr_sec & i_reg_wdata[sbg_pkg::SEC_FLUSH]) | mode_off // [RULE9]
		| run_rise // [RULE10]
		| (auto_tr & ~gate_eff & ~combo) // [RULE1] [RULE9]
		| (combo & go_sleep); // [RULE13] [RULE18]

	// Sample path: store, circular drop or discard
	logic stream_full, can_store, drop, disc, post_end;
	assign stream_full = (cnt_ff == sbg_pkg::BUF_DEPTH);
	assign post_end = ({1'b0, post_ff} + 7'h01) >= ({1'b0, sbg_pkg::BUF_DEPTH} - {1'b0, wm});
	assign disc = tick & gate_closed_ff & (mode != sbg_pkg::MODE_DISABLED) & ~flush; // [RULE2]
	// Combinational store decision per collection mode
	always_comb begin
		can_store = 1'b0;
		drop = 1'b0;
		unique case (mode)
			sbg_pkg::MODE_DISABLED: begin
				can_store = 1'b0; // Nothing collected
			end
			sbg_pkg::MODE_STREAM: begin
				can_store = 1'b1;
				drop = stream_full; // Oldest sample overwritten
			end
			sbg_pkg::MODE_STOP: begin
				can_store = ~stream_full; // Stops when full
			end
			sbg_pkg::MODE_TRIGGER: begin
				if (trg_ff == sbg_pkg::TRG_PRE) begin
					// Circular window of at most watermark_level samples
					can_store = (wm != 6'h00); // [RULE14]
					drop = (cnt_ff >= wm); // [RULE14]
				end else if (trg_ff == sbg_pkg::TRG_POST) begin
					can_store = 1'b1; // [RULE16]
				end else begin
					can_store = 1'b0; // Halted until emptied or flushed
				end
			end
		endcase
	end
	// Closed gate or a flush in progress blocks storing
	assign o_store = tick & run & can_store & ~gate_closed_ff & ~flush; // [RULE5]
	assign o_drop_oldest = o_store & drop;
	assign emptied = rd & (cnt_ff == 6'h01) & ~(o_store & ~drop);
	assign clr_all = flush | emptied;

	// Next sample count, used by the watermark flag too
	logic [5:0] nxt_cnt;
	always_comb begin
		nxt_cnt = cnt_ff;
		if (flush || mode == sbg_pkg::MODE_DISABLED) begin
			nxt_cnt = 6'h00; // [RULE11]
		end else if (o_store && !drop && !rd) begin
			nxt_cnt = cnt_ff + 6'h01;
		end else if (rd && !(o_store && !drop)) begin
			nxt_cnt = cnt_ff - 6'h01;
		end
	end

	// Register writes; flush_request is never stored so it self-clears
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_pri_ff <= sbg_pkg::CFG_PRI_RST;
			cfg_sec_ff <= sbg_pkg::CFG_SEC_RST[6:0];
		end else begin
			if (wr_pri) begin
				cfg_pri_ff <= i_reg_wdata; // [RULE21]
			end
			if (wr_sec) begin
				cfg_sec_ff <= i_reg_wdata[6:0]; // [RULE20] [RULE22]
			end
		end
	end

	// Register read data, flush_request always reads zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_ff <= 8'h00;
		end else if (i_ce && i_reg_rd) begin
			if (i_reg_addr == sbg_pkg::ADDR_CFG_PRI) begin
				rdata_ff <= cfg_pri_ff;
			end else if (i_reg_addr == sbg_pkg::ADDR_CFG_SEC) begin
				rdata_ff <= {1'b0, cfg_sec_ff}; // [RULE22]
			end else begin
				rdata_ff <= 8'h00; // Unmapped offsets read zero
			end
		end
	end

	// Power mode and autosleep timer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pwr_ff <= sbg_pkg::PWR_WAKE;
			timer_ff <= 8'h00;
			run_ff <= 1'b0;
		end else if (i_ce) begin
			run_ff <= run;
			if (!run || run_rise) begin
				pwr_ff <= sbg_pkg::PWR_WAKE; // [RULE13]
				timer_ff <= 8'h00;
			end else if (go_sleep) begin
				pwr_ff <= sbg_pkg::PWR_SLEEP; // Mode changes even with gate on [RULE5]
				timer_ff <= 8'h00;
			end else if (go_wake) begin
				pwr_ff <= sbg_pkg::PWR_WAKE;
				timer_ff <= 8'h00;
			end else if (keep_awake || rd) begin
				timer_ff <= 8'h00; // Host activity restarts the wait
			end else if (tick && pwr_ff == sbg_pkg::PWR_WAKE) begin
				timer_ff <= timer_ff + 8'h01;
			end
		end
	end

	// Triggered collection phase
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			trg_ff <= sbg_pkg::TRG_PRE;
			post_ff <= 6'h00;
		end else if (i_ce) begin
			if (clr_all || mode != sbg_pkg::MODE_TRIGGER) begin
				trg_ff <= sbg_pkg::TRG_PRE; // Rearm [RULE17]
				post_ff <= 6'h00;
			end else if (trig_take) begin
				trg_ff <= sbg_pkg::TRG_POST; // Later triggers ignored [RULE15]
			end else if (trg_ff == sbg_pkg::TRG_POST && o_store) begin
				post_ff <= post_ff + 6'h01;
				if (post_end) begin
					trg_ff <= sbg_pkg::TRG_HALT; // [RULE16]
				end
			end
		end
	end

	// Input gate; a transition with an empty buffer leaves nothing to guard
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gate_closed_ff <= 1'b0;
		end else if (i_ce) begin
			if (auto_tr && gate_eff && !flush && nxt_cnt != 6'h00) begin
				gate_closed_ff <= 1'b1; // [RULE2]
			end else if (clr_all || mode == sbg_pkg::MODE_DISABLED) begin
				gate_closed_ff <= 1'b0; // Reopens at current mode rate [RULE6]
			end
		end
	end

	// Sample count, watermark and overflow
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_ff <= 6'h00;
			wm_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else if (i_ce) begin
			cnt_ff <= nxt_cnt;
			wm_ff <= (wm != 6'h00) && (nxt_cnt >= wm); // [RULE23]
			// A new overflow beats an empty-read clear in the same cycle
			if (o_store && ((mode == sbg_pkg::MODE_STREAM && stream_full)
				|| (trg_ff == sbg_pkg::TRG_POST && post_end))) begin
				ovf_ff <= 1'b1; // [RULE16]
			end else if (tick && mode == sbg_pkg::MODE_STOP && stream_full && !flush) begin
				ovf_ff <= 1'b1;
			end else if (clr_all || mode == sbg_pkg::MODE_DISABLED) begin
				ovf_ff <= 1'b0; // [RULE11]
			end
		end
	end

	// Discard flag and saturating discard counter; a discard beats a clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			disc_ff <= 1'b0;
			disc_cnt_ff <= 5'h00;
		end else if (i_ce) begin
			if (disc) begin
				disc_ff <= 1'b1; // [RULE3]
				if (clr_all) begin
					disc_cnt_ff <= 5'h01;
				end else if (disc_cnt_ff != sbg_pkg::DISC_MAX) begin
					disc_cnt_ff <= disc_cnt_ff + 5'h01; // [RULE4] [RULE24]
				end
			end else if (clr_all || mode == sbg_pkg::MODE_DISABLED) begin
				disc_ff <= 1'b0; // [RULE12]
				disc_cnt_ff <= 5'h00; // [RULE12]
			end
		end
	end

	// Flush indication to the buffer memory, one cycle after the decision
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flush_ff <= 1'b0;
		end else if (i_ce) begin
			flush_ff <= flush;
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_wake = (pwr_ff == sbg_pkg::PWR_WAKE);
	assign o_flush = flush_ff;
	assign o_read_newest_first = cfg_pri_ff[sbg_pkg::PRI_READ_ORDER];
	assign o_sample_count = cnt_ff;
	assign o_overflow_flag = ovf_ff;
	assign o_watermark_flag = wm_ff;
	assign o_gate_discard_flag = disc_ff;
	assign o_gate_discard_count = disc_cnt_ff;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_ungated_flush;
		i_ce && auto_tr && !gate_eff && !combo |=> o_flush && cnt_ff == 6'h00;
	endproperty
	a_ungated_flush: assert property (p_ungated_flush) else $error("no flush on transition"); // [RULE1]

	property p_gate_blocks;
		gate_closed_ff |-> !o_store;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("sample stored through gate"); // [RULE2]

	property p_disc_flag;
		i_ce && disc |=> o_gate_discard_flag && o_gate_discard_count != 5'h00;
	endproperty
	a_disc_flag: assert property (p_disc_flag) else $error("discard not flagged"); // [RULE3]

	property p_disc_count;
		i_ce && disc && !clr_all && disc_cnt_ff < sbg_pkg::DISC_MAX
			|=> disc_cnt_ff == $past(disc_cnt_ff) + 5'h01;
	endproperty
	a_disc_count: assert property (p_disc_count) else $error("discard count wrong"); // [RULE4]

	property p_flush_clears;
		i_ce && flush && !disc |=> cnt_ff == 6'h00 && !o_gate_discard_flag && !wm_ff;
	endproperty
	a_flush_clears: assert property (p_flush_clears) else $error("flush left state"); // [RULE12]

	property p_flush_reads_zero;
		i_ce && i_reg_rd && i_reg_addr == sbg_pkg::ADDR_CFG_SEC |=> !o_reg_rdata[7];
	endproperty
	a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("flush bit seen"); // [RULE22]

	property p_post_stays_awake;
		combo && trg_ff != sbg_pkg::TRG_PRE && o_wake && run ##1 run |-> o_wake;
	endproperty
	a_post_stays_awake: assert property (p_post_stays_awake) else $error("slept after trigger"); // [RULE15]

	property p_no_disabled_trigger;
		i_ce && trg_ff == sbg_pkg::TRG_PRE && cfg_pri_ff[3:0] == 4'h0 && !clr_all
			|=> trg_ff == sbg_pkg::TRG_PRE;
	endproperty
	a_no_disabled_trigger: assert property (p_no_disabled_trigger) else $error("bad trigger"); // [RULE8]

	property p_post_overflow;
		i_ce && trg_ff == sbg_pkg::TRG_POST && o_store && post_end && !clr_all
			|=> o_overflow_flag && trg_ff == sbg_pkg::TRG_HALT;
	endproperty
	a_post_overflow: assert property (p_post_overflow) else $error("no stop after post"); // [RULE16]
endmodule

/* File: verilog/sbg_pkg.sv */
// Constants, register map and state encodings for the sample buffer gate and trigger control
package sbg_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_CFG_PRI = 8'h26; // buffer_config_primary
	localparam logic [7:0] ADDR_CFG_SEC = 8'h27; // buffer_config_secondary
	// Reset values
	localparam logic [7:0] CFG_PRI_RST = 8'h00;
	localparam logic [7:0] CFG_SEC_RST = 8'h00;
	// buffer_config_primary field positions
	localparam int PRI_READ_ORDER = 7; // 0 oldest first, 1 newest first
	localparam int PRI_MODE_HI = 6;
	localparam int PRI_MODE_LO = 5;
	localparam int PRI_GATE_EN = 4; // input_gate_enable
	localparam int PRI_TRIG_WT = 3; // trig_within_threshold_en
	localparam int PRI_TRIG_OT = 2; // trig_outside_threshold_en
	localparam int PRI_TRIG_OR = 0; // trig_orientation_en
	// buffer_config_secondary field positions
	localparam int SEC_FLUSH = 7; // flush_request
	localparam int SEC_KEEP_AWAKE = 6; // buffer_keeps_awake_en
	localparam int SEC_WM_HI = 5;
	localparam int SEC_WM_LO = 0;
	// Buffer geometry and counter limits
	localparam logic [5:0] BUF_DEPTH = 6'h20; // 32 samples
	localparam logic [4:0] DISC_MAX = 5'h1f; // discard counter saturates here
	// collection_mode encodings
	typedef enum logic [1:0] {
		MODE_DISABLED = 2'b00,
		MODE_STREAM = 2'b01,
		MODE_STOP = 2'b10,
		MODE_TRIGGER = 2'b11
	} sbg_mode_e;
	// Automatic power mode
	typedef enum logic {
		PWR_SLEEP = 1'b0,
		PWR_WAKE = 1'b1
	} sbg_pwr_e;
	// Triggered collection phase
	typedef enum logic [1:0] {
		TRG_PRE = 2'b00,
		TRG_POST = 2'b01,
		TRG_HALT = 2'b10
	} sbg_trg_e;
endpackage
